//--- core/apsc_ctrl.sv
// Protection switching control: remote decode, global request, bridge, selector, defects, sent signal.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "apsc_regs.svh"

module apsc_ctrl
  import apsc_pkg::*;
#(
  parameter int PERSIST_CYC = `APSC_PERSIST_CYC
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [3:0] i_accepted_req_code,
  input wire logic [3:0] i_accepted_req_number,
  input wire logic [3:0] i_accepted_bridged_number,
  input wire logic i_accepted_architecture,
  input wire logic i_protection_fail,
  input wire logic i_server_signal_fail_in,
  output logic [3:0] o_sent_req_code,
  output logic [3:0] o_sent_req_number,
  output logic [3:0] o_sent_bridged_number,
  output logic o_sent_architecture,
  output logic [3:0] o_local_bridged_num,
  output logic [3:0] o_selected_signal_num,
  output logic [3:0] o_defects,
  output logic o_protocol_failure_cause
);

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic local_arch_reg;
  logic bidir_reg;
  logic chan_used_reg;
  apsc_num_t n_work_reg;
  apsc_req_e local_req_type_reg;
  apsc_num_t local_signal_num_reg;
  logic [15:0] lockout_reg;
  apsc_req_e global_req_type_reg;
  apsc_num_t global_signal_num_reg;
  logic [3:0] defect_reg;

  function automatic apsc_req_e apsc_decode(input logic [3:0] code);
    apsc_req_e t;
    unique case (code)
      4'h3, 4'h5, 4'h7, 4'h9: t = APSC_NO_REQUEST;
      default: t = apsc_req_e'(code);
    endcase
    return t;
  endfunction

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      local_arch_reg <= 1'b0;
      bidir_reg <= 1'b0;
      chan_used_reg <= 1'b0;
      n_work_reg <= `APSC_NWORK_RESET;
    end
    else if (i_wr && i_addr == `APSC_ADDR_CONFIG)
    begin
      local_arch_reg <= i_wdata[`APSC_CFG_ARCH_BIT];
      bidir_reg <= i_wdata[`APSC_CFG_BIDIR_BIT];
      chan_used_reg <= i_wdata[`APSC_CFG_CHAN_BIT];
      n_work_reg <= i_wdata[`APSC_CFG_NWORK_LSB +: 4];
    end
  end

  // An invalid local code is stored as no request, so no invalid code can ever reach the line.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      local_req_type_reg <= APSC_NO_REQUEST;
      local_signal_num_reg <= `APSC_NULL_NUM;
    end
    else if (i_wr && i_addr == `APSC_ADDR_LOCAL_REQ)
    begin
      local_req_type_reg <= apsc_decode(i_wdata[3:0]);
      local_signal_num_reg <= i_wdata[`APSC_LREQ_NUM_LSB +: 4];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      lockout_reg <= 16'h0000;
    else if (i_wr && i_addr == `APSC_ADDR_LOCKOUT)
      lockout_reg <= i_wdata[15:0];
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
    begin
      unique case (i_addr)
        `APSC_ADDR_CONFIG: o_rdata <= {24'h00_0000, n_work_reg, 1'b0, chan_used_reg, bidir_reg, local_arch_reg};
        `APSC_ADDR_LOCAL_REQ: o_rdata <= {24'h00_0000, local_signal_num_reg, local_req_type_reg};
        `APSC_ADDR_LOCKOUT: o_rdata <= {16'h0000, lockout_reg};
        `APSC_ADDR_STATUS: o_rdata <= {8'h00, o_local_bridged_num, o_selected_signal_num, global_signal_num_reg,
                                       global_req_type_reg, 3'h0, o_protocol_failure_cause, defect_reg};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end
    else
      o_rdata <= 32'h0000_0000;
  end

  // ****************************************************************
  // Remote request interpretation
  // ****************************************************************
  apsc_num_t remote_req_signal_num;
  apsc_num_t remote_bridged_num;
  logic remote_arch;
  logic code_invalid;
  logic num_invalid;
  apsc_req_e remote_req_type;

  assign remote_req_signal_num = i_accepted_req_number;
  assign remote_bridged_num = i_accepted_bridged_number;
  assign remote_arch = i_accepted_architecture;
  assign code_invalid = (apsc_decode(i_accepted_req_code) == APSC_NO_REQUEST) && (i_accepted_req_code != 4'h0);
  // Number 0 is protection, 1 to n the working trails, so anything above n does not exist.
  assign num_invalid = (remote_req_signal_num > n_work_reg) || (remote_bridged_num > n_work_reg);

  always_comb
  begin
    remote_req_type = apsc_decode(i_accepted_req_code);
    if (remote_req_signal_num != `APSC_NULL_NUM && lockout_reg[remote_req_signal_num])
      remote_req_type = APSC_NO_REQUEST;
  end

  // ****************************************************************
  // Global request
  // ****************************************************************
  apsc_req_e global_req_type_next;
  apsc_num_t global_signal_num_next;
  logic remote_wins;

  always_comb
  begin
    remote_wins = (remote_req_type > local_req_type_reg) ||
                  ((remote_req_type == local_req_type_reg) && (remote_req_type > APSC_NO_REQUEST) &&
                   ((global_req_type_reg == APSC_REVERSE_REQUEST) ||
                    (remote_req_signal_num < local_signal_num_reg)));
    if (bidir_reg && !i_protection_fail && remote_req_type != APSC_REVERSE_REQUEST && remote_wins)
    begin
      global_req_type_next = APSC_REVERSE_REQUEST;
      global_signal_num_next = remote_req_signal_num;
    end
    else
    begin
      global_req_type_next = local_req_type_reg;
      global_signal_num_next = local_signal_num_reg;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      global_req_type_reg <= APSC_NO_REQUEST;
      global_signal_num_reg <= `APSC_NULL_NUM;
    end
    else
    begin
      global_req_type_reg <= global_req_type_next;
      global_signal_num_reg <= global_signal_num_next;
    end
  end

  // ****************************************************************
  // Protocol defects
  // ****************************************************************
  // Index 0 architecture, 1 invalid command, 2 acknowledge timeout, 3 selector mismatch.
  logic [3:0] defect_cond;
  logic ack_ok;

  assign ack_ok = ((remote_req_type == APSC_REVERSE_REQUEST) && (remote_req_signal_num == global_signal_num_reg)) ||
                  (remote_req_type >= local_req_type_reg);
  assign defect_cond[0] = remote_arch != local_arch_reg;
  assign defect_cond[1] = code_invalid || num_invalid;
  assign defect_cond[2] = !ack_ok && !i_protection_fail;
  assign defect_cond[3] = (remote_bridged_num != global_signal_num_reg) && !i_protection_fail;

  // Each defect needs an unbroken run of its condition; any break restarts the count and clears it.
  for (genvar g = 0; g < 4; g++)
  begin : g_persist
    logic [31:0] cnt_reg;
    always_ff @(posedge i_sys_clk)
    begin
      if (!i_rst_n || !defect_cond[g])
        cnt_reg <= 32'h0000_0000;
      else if (cnt_reg < 32'(PERSIST_CYC))
        cnt_reg <= cnt_reg + 32'h0000_0001;
    end
    always_ff @(posedge i_sys_clk)
    begin
      if (!i_rst_n)
        defect_reg[g] <= 1'b0;
      else
        defect_reg[g] <= defect_cond[g] && (cnt_reg >= 32'(PERSIST_CYC) - 32'h0000_0001);
    end
  end

  assign o_defects = defect_reg;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_protocol_failure_cause <= 1'b0;
    else
      o_protocol_failure_cause <= (|defect_reg) && !i_server_signal_fail_in;
  end

  // ****************************************************************
  // Bridge and selector
  // ****************************************************************
  logic healthy;

  assign healthy = !i_protection_fail && !(|defect_reg);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_local_bridged_num <= `APSC_NULL_NUM;
    else if (!local_arch_reg)
      o_local_bridged_num <= `APSC_PERM_BRIDGE;
    else if (healthy)
      o_local_bridged_num <= remote_req_signal_num;
    else if (bidir_reg)
      o_local_bridged_num <= `APSC_NULL_NUM;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_selected_signal_num <= `APSC_NULL_NUM;
    else if (!local_arch_reg && !bidir_reg)
      o_selected_signal_num <= (i_protection_fail && chan_used_reg) ? `APSC_NULL_NUM : local_signal_num_reg;
    else if (global_signal_num_reg == remote_bridged_num && healthy)
      o_selected_signal_num <= global_signal_num_reg;
    else
      o_selected_signal_num <= `APSC_NULL_NUM;
  end

  // ****************************************************************
  // Sent signal
  // ****************************************************************
  // A null remote number forces a null bridged indication, so an idle trail reads null at both ends.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_sent_req_code <= APSC_NO_REQUEST;
      o_sent_req_number <= `APSC_NULL_NUM;
      o_sent_bridged_number <= `APSC_NULL_NUM;
      o_sent_architecture <= 1'b0;
    end
    else
    begin
      o_sent_req_code <= global_req_type_reg;
      o_sent_req_number <= global_signal_num_reg;
      o_sent_bridged_number <= (remote_req_signal_num == `APSC_NULL_NUM) ? `APSC_NULL_NUM
                                                                          : o_local_bridged_num;
      o_sent_architecture <= local_arch_reg;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_sent_code_valid: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !(o_sent_req_code inside {4'h3, 4'h5, 4'h7, 4'h9}))
    else $error("invalid request code sent");

  chk_sel_released: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (|defect_reg) && (local_arch_reg || bidir_reg) |=> o_selected_signal_num == 4'h0)
    else $error("selector held during protocol defect");

  chk_perm_bridge: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rst_n && !local_arch_reg |=> o_local_bridged_num == 4'h1)
    else $error("1+1 bridge not on signal 1");

  chk_fail_cause_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (|defect_reg) && !i_server_signal_fail_in |=> o_protocol_failure_cause)
    else $error("failure cause missing");

  chk_arch_sent: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ##1 o_sent_architecture == $past(local_arch_reg))
    else $error("sent architecture bit wrong");

  chk_arch_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    defect_reg[0] && remote_arch == local_arch_reg |=> !defect_reg[0])
    else $error("architecture defect not cleared on match");

  chk_defect_rise: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(defect_reg[3]) |-> $past(g_persist[3].cnt_reg) == 32'(PERSIST_CYC) - 32'h0000_0001)
    else $error("selector mismatch raised early");

  chk_global_local: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !bidir_reg |=> global_req_type_reg == $past(local_req_type_reg) &&
                   global_signal_num_reg == $past(local_signal_num_reg))
    else $error("global request differs from local");

  chk_null_bridged: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    remote_req_signal_num == 4'h0 |=> o_sent_bridged_number == 4'h0)
    else $error("bridged number not null");

  chk_bridge_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rst_n && local_arch_reg && healthy |=> o_local_bridged_num == $past(remote_req_signal_num))
    else $error("bridge does not follow remote number");

  chk_bridge_drop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rst_n && local_arch_reg && bidir_reg && !healthy |=> o_local_bridged_num == 4'h0)
    else $error("bridge kept while unhealthy");

  chk_sel_local: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rst_n && !local_arch_reg && !bidir_reg && !(i_protection_fail && chan_used_reg) |=>
      o_selected_signal_num == $past(local_signal_num_reg))
    else $error("selector not on local number");

  chk_sent_number: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rst_n |=> o_sent_req_number == $past(global_signal_num_reg))
    else $error("sent number differs from global number");

  chk_timeout_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_protection_fail |=> !defect_reg[2])
    else $error("timeout defect kept during protection fail");

  chk_mismatch_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_protection_fail |=> !defect_reg[3])
    else $error("selector mismatch kept during protection fail");

  chk_invalid_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !code_invalid && !num_invalid |=> !defect_reg[1])
    else $error("invalid command defect kept");

  chk_lockout_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_rst_n && local_req_type_reg == APSC_NO_REQUEST && remote_req_signal_num != 4'h0 &&
      lockout_reg[remote_req_signal_num] |=> global_req_type_reg == APSC_NO_REQUEST)
    else $error("locked out remote request accepted");

  chk_fail_cause_ssf: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_server_signal_fail_in |=> !o_protocol_failure_cause)
    else $error("failure cause during server signal fail");

endmodule

//--- core/apsc_regs.svh
// Constants for the protection switching controller: offsets, fields, codes and timing.
//
// Contract
// - Remote number, bridged number and architecture come straight from the accepted fields.
// - Accepted 4-bit code maps to remote request type; 0011,0101,0111,1001 are invalid.
// - Architecture mismatch defect after 50 ms of difference; clears at once on match.
// - Invalid command defect after 50 ms of bad code or number; clears when valid.
// - Remote requests for a locally locked-out normal signal are ignored.
// - Global request ranks local and remote by type priority, ignoring received reverse request.
// - Bidirectional, no protection fail, remote higher or tied above none with lower number or global reverse: global is reverse request, remote number.
// - Otherwise global type and number equal the local type and number.
// - Acknowledge timeout after 50 ms of non-compliant far end; clears on compliance or protection fail.
// - In 1+1 normal signal 1 is permanently bridged.
// - In 1:n bridge follows remote number when healthy; else 0 if bidirectional, hold if not.
// - 1+1 unidirectional selects local number; releases when protection fails with channel used.
// - Otherwise select global number only if equal to remote bridged, healthy; else release.
// - Selector mismatch defect after 50 ms of difference; clears on match or protection fail.
// - Any of the four protocol defects releases the selector; the code keeps the local number selected in 1+1 unidirectional.
// - Sent number is global number; sent bridged is 0 if remote number 0, else local bridged.
// - Sent architecture bit is 0 for 1+1 and 1 for 1:n.
// - Global type is encoded to a valid 4-bit sent code, never an invalid one.
// - An unused protection trail shows null number and null bridged; any bridged signal accepted; the code still raises selector mismatch for a non-null bridged.
// - Signal number 0 is the protection trail, 1 to n are working trails.
`ifndef APSC_REGS_SVH
`define APSC_REGS_SVH

`define APSC_ADDR_CONFIG 8'h00
`define APSC_ADDR_LOCAL_REQ 8'h04
`define APSC_ADDR_LOCKOUT 8'h08
`define APSC_ADDR_STATUS 8'h0c

`define APSC_CFG_ARCH_BIT 0
`define APSC_CFG_BIDIR_BIT 1
`define APSC_CFG_CHAN_BIT 2
`define APSC_CFG_NWORK_LSB 4
`define APSC_LREQ_NUM_LSB 4
`define APSC_ST_FAIL_BIT 4
`define APSC_ST_GTYPE_LSB 8
`define APSC_ST_GNUM_LSB 12
`define APSC_ST_SEL_LSB 16
`define APSC_ST_BRG_LSB 20

`define APSC_NWORK_RESET 4'h1
`define APSC_NULL_NUM 4'h0
`define APSC_PERM_BRIDGE 4'h1

`define APSC_PERSIST_MS 50
`define APSC_CLK_NS 10
`define APSC_PERSIST_CYC (`APSC_PERSIST_MS * (1000000 / `APSC_CLK_NS))

`endif

//--- core/apsc_pkg.sv
// Types shared by the protection switching controller.
package apsc_pkg;

  // Codes follow request priority, so a plain compare ranks them.
  typedef enum logic [3:0] {
    APSC_NO_REQUEST = 4'h0,
    APSC_DO_NOT_REVERT = 4'h1,
    APSC_REVERSE_REQUEST = 4'h2,
    APSC_TRIAL_SWITCH = 4'h4,
    APSC_WAIT_TO_RESTORE = 4'h6,
    APSC_MANUAL_SWITCH = 4'h8,
    APSC_DEGRADE_LOW_PRIO = 4'ha,
    APSC_DEGRADE_HIGH_PRIO = 4'hb,
    APSC_FAIL_LOW_PRIO = 4'hc,
    APSC_FAIL_HIGH_PRIO = 4'hd,
    APSC_FORCED_SWITCH = 4'he,
    APSC_PROTECTION_BARRED = 4'hf
  } apsc_req_e;

  typedef logic [3:0] apsc_num_t;

endpackage

//--- verif/apsc_peer_model.sv
// Far-end protection controller model that drives the accepted APS fields.
`timescale 1ns/1ps

module apsc_peer_model
  import apsc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_echo,
  input wire logic i_slow,
  input wire logic [3:0] i_code,
  input wire logic [3:0] i_num,
  input wire logic [3:0] i_brg,
  input wire logic i_arch,
  input wire logic [3:0] i_sent_req_number,
  output logic [3:0] o_code,
  output logic [3:0] o_num,
  output logic [3:0] o_brg,
  output logic o_arch
);
  // ****************
  // Answer delay
  // ****************
  apsc_num_t hist [0:23];
  apsc_num_t tap;

  // A slow head end answers 24 cycles late, well past the persistence window.
  always_ff @(posedge i_sys_clk)
  begin
    hist[0] <= i_sent_req_number;
    for (int k = 1; k < 24; k++)
    begin
      hist[k] <= hist[k-1];
    end
  end

  assign tap = i_slow ? hist[23] : hist[0];

  // ****************
  // Head-end answer
  // ****************
  always_comb
  begin
    o_arch = i_arch;
    if (i_echo)
    begin
      o_code = (tap == 4'h0) ? 4'h0 : 4'h2;
      o_num = tap;
      o_brg = tap;
    end
    else
    begin
      o_code = i_code;
      o_num = i_num;
      o_brg = i_brg;
    end
  end
endmodule

//--- verif/apsc_ctrl_test.sv
// Self-checking testbench for the protection switching controller.
`timescale 1ns/1ps
`include "apsc_regs.svh"

module apsc_ctrl_test;
  import apsc_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, pf = 1'h0, ssf = 1'h0;
  logic echo = 1'h0, slow = 1'h0, r_arch = 1'h0, bad, a_arch, s_arch, pfc;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] r_code = 4'h0, r_num = 4'h0, r_brg = 4'h0;
  logic [3:0] a_code, a_num, a_brg, s_code, s_num, s_brg, lbn, sel, dfx;
  int err_count = 0, n_checks = 0;

  always #5 clk = ~clk;

  apsc_ctrl #(.PERSIST_CYC(8)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_accepted_req_code(a_code), .i_accepted_req_number(a_num),
    .i_accepted_bridged_number(a_brg), .i_accepted_architecture(a_arch), .i_protection_fail(pf),
    .i_server_signal_fail_in(ssf), .o_sent_req_code(s_code), .o_sent_req_number(s_num),
    .o_sent_bridged_number(s_brg), .o_sent_architecture(s_arch), .o_local_bridged_num(lbn),
    .o_selected_signal_num(sel), .o_defects(dfx), .o_protocol_failure_cause(pfc));

  apsc_peer_model PEER (.i_sys_clk(clk), .i_echo(echo), .i_slow(slow), .i_code(r_code), .i_num(r_num),
    .i_brg(r_brg), .i_arch(r_arch), .i_sent_req_number(s_num), .o_code(a_code), .o_num(a_num),
    .o_brg(a_brg), .o_arch(a_arch));

  // ****************
  // Access and compare tasks
  // ****************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] seen);
    check(what, {28'h0, exp}, {28'h0, seen});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    check("rdata", exp, rdata);
  endtask

  task automatic remote(input logic [3:0] c, input logic [3:0] n, input logic [3:0] b, input logic ar);
    @(posedge clk);
    r_code <= c;
    r_num <= n;
    r_brg <= b;
    r_arch <= ar;
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && n_checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    cyc(3);
    chk4("sent_arch", 4'h0, {3'h0, s_arch});
    chk4("bridge", 4'h1, lbn);
    chk4("sent_brg", 4'h0, s_brg);
    rd_chk(`APSC_ADDR_CONFIG, 32'h10);
    rd_chk(`APSC_ADDR_LOCAL_REQ, 32'h0);
    rd_chk(`APSC_ADDR_LOCKOUT, 32'h0);
    rd_chk(8'h10, 32'h0);
    wr_reg(`APSC_ADDR_CONFIG, 32'h34);
    wr_reg(`APSC_ADDR_LOCAL_REQ, 32'h1e);
    cyc(3);
    chk4("select", 4'h1, sel);
    @(posedge clk) pf <= 1'h1;
    cyc(3);
    chk4("select", 4'h0, sel);
    wr_reg(`APSC_ADDR_CONFIG, 32'h30);
    cyc(3);
    chk4("select", 4'h1, sel);
    @(posedge clk) pf <= 1'h0;
    wr_reg(`APSC_ADDR_LOCAL_REQ, 32'h0);
    remote(4'h0, 4'h0, 4'h0, 1'h1);
    wr_reg(`APSC_ADDR_CONFIG, 32'h37);
    cyc(3);
    rd_chk(`APSC_ADDR_CONFIG, 32'h37);
    chk4("sent_arch", 4'h1, {3'h0, s_arch});
    for (int c = 0; c < 16; c++)
    begin
      bad = (c == 3) || (c == 5) || (c == 7) || (c == 9) || (c == 0) || (c == 2);
      remote(4'(c), 4'h1, 4'h1, 1'h1);
      cyc(4);
      chk4("sent_code", bad ? 4'h0 : 4'h2, s_code);
      chk4("sent_num", bad ? 4'h0 : 4'h1, s_num);
    end
    remote(4'h0, 4'h0, 4'h0, 1'h1);
    wr_reg(`APSC_ADDR_LOCAL_REQ, 32'h38);
    remote(4'h8, 4'h3, 4'h0, 1'h1);
    cyc(3);
    chk4("sent_code", 4'h8, s_code);
    remote(4'h8, 4'h2, 4'h0, 1'h1);
    cyc(3);
    chk4("sent_num", 4'h2, s_num);
    remote(4'h8, 4'h3, 4'h0, 1'h1);
    cyc(3);
    chk4("sent_code", 4'h2, s_code);
    remote(4'h0, 4'h0, 4'h0, 1'h1);
    for (int c = 0; c < 16; c++)
    begin
      bad = (c == 3) || (c == 5) || (c == 7) || (c == 9);
      wr_reg(`APSC_ADDR_LOCAL_REQ, 32'h10 | 32'(c));
      cyc(3);
      chk4("sent_code", bad ? 4'h0 : 4'(c), s_code);
      chk4("sent_num", 4'h1, s_num);
    end
    wr_reg(`APSC_ADDR_LOCAL_REQ, 32'h0);
    wr_reg(`APSC_ADDR_LOCKOUT, 32'h4);
    remote(4'hc, 4'h2, 4'h0, 1'h1);
    cyc(4);
    chk4("sent_code", 4'h0, s_code);
    wr_reg(`APSC_ADDR_LOCKOUT, 32'h0);
    remote(4'hc, 4'h2, 4'h2, 1'h1);
    cyc(4);
    chk4("sent_code", 4'h2, s_code);
    chk4("select", 4'h2, sel);
    chk4("bridge", 4'h2, lbn);
    chk4("sent_brg", 4'h2, s_brg);
    remote(4'hc, 4'h2, 4'h2, 1'h0);
    cyc(4);
    chk4("defects", 4'h0, dfx);
    cyc(8);
    chk4("defects", 4'h1, dfx);
    chk4("select", 4'h0, sel);
    chk4("bridge", 4'h0, lbn);
    chk4("fail_cause", 4'h1, {3'h0, pfc});
    rd_chk(`APSC_ADDR_STATUS, 32'h0000_2211);
    remote(4'hc, 4'h2, 4'h2, 1'h1);
    cyc(2);
    chk4("defects", 4'h0, dfx);
    remote(4'h3, 4'h0, 4'h0, 1'h1);
    cyc(4);
    chk4("defects", 4'h0, dfx);
    cyc(8);
    chk4("defects", 4'h2, dfx);
    @(posedge clk) ssf <= 1'h1;
    cyc(2);
    chk4("fail_cause", 4'h0, {3'h0, pfc});
    @(posedge clk) ssf <= 1'h0;
    remote(4'h0, 4'h5, 4'h0, 1'h1);
    cyc(4);
    chk4("defects", 4'h2, dfx);
    remote(4'h0, 4'h0, 4'h0, 1'h1);
    cyc(2);
    chk4("defects", 4'h0, dfx);
    @(posedge clk) echo <= 1'h1;
    wr_reg(`APSC_ADDR_LOCAL_REQ, 32'h1c);
    cyc(20);
    chk4("defects", 4'h0, dfx);
    chk4("select", 4'h1, sel);
    @(posedge clk) pf <= 1'h1;
    cyc(3);
    chk4("select", 4'h0, sel);
    chk4("bridge", 4'h0, lbn);
    @(posedge clk) pf <= 1'h0;
    slow <= 1'h1;
    wr_reg(`APSC_ADDR_LOCAL_REQ, 32'h2c);
    cyc(14);
    chk4("defects", 4'hc, dfx);
    cyc(30);
    chk4("defects", 4'h0, dfx);
    tally_and_finish;
  end
endmodule
